/* hdl/tcoc_pkg.sv */
// Constants shared by the 8-bit timer/counter with two compare channels.
package tcoc_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] OFS_COUNT   = 8'h00;
  localparam logic [7:0] OFS_CMP_A   = 8'h04;
  localparam logic [7:0] OFS_CMP_B   = 8'h08;
  localparam logic [7:0] OFS_CTRL_A  = 8'h0c;
  localparam logic [7:0] OFS_CTRL_B  = 8'h10;
  localparam logic [7:0] OFS_MASK    = 8'h14;
  localparam logic [7:0] OFS_FLAGS   = 8'h18;

  // Field positions in timer_control_a.
  localparam int CTA_WGM_POS  = 0;
  localparam int CTA_COMB_POS = 4;
  localparam int CTA_COMA_POS = 6;

  // Field positions in timer_control_b.
  localparam int CTB_CS_POS   = 0;
  localparam int CTB_WGM2_POS = 3;
  localparam int CTB_FOCB_POS = 6;
  localparam int CTB_FOCA_POS = 7;

  // Bit positions in timer_irq_flags and timer_irq_mask.
  localparam int FLG_OVF   = 0;
  localparam int FLG_CMP_A = 1;
  localparam int FLG_CMP_B = 2;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_PSC  = 10'h000;

  // Count extremes.
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;

  // Prescaler taps, as the number of low prescaler bits that must be ones.
  localparam int PSC_W       = 10;
  localparam int DIV8_BITS   = 3;
  localparam int DIV64_BITS  = 6;
  localparam int DIV256_BITS = 8;
  localparam int DIV1024_BITS = 10;

  // Clock select codes.
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Waveform mode codes.
  localparam logic [2:0] WGM_NORMAL   = 3'h0;
  localparam logic [2:0] WGM_PC_MAX   = 3'h1;
  localparam logic [2:0] WGM_CTC      = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_OCA   = 3'h5;
  localparam logic [2:0] WGM_FAST_OCA = 3'h7;

  // Compare output field codes.
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

endpackage

/* hdl/tcoc_timer.sv */
// Timer/counter with two compare channels behind a Wishbone slave.
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module tcoc_timer (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_count_pin,
  input  wire logic        irq_ack_ovf,
  input  wire logic        irq_ack_cmp_a,
  input  wire logic        irq_ack_cmp_b,
  output logic             irq_ovf,
  output logic             irq_cmp_a,
  output logic             irq_cmp_b,
  output logic             wave_out_a,
  output logic             wave_out_b,
  output logic             wave_oe_a,
  output logic             wave_oe_b
);
  import tcoc_pkg::*;

  typedef struct packed {
    logic [7:0]       cnt;
    logic [7:0]       ocr_a;
    logic [7:0]       ocr_b;
    logic [7:0]       buf_a;
    logic [7:0]       buf_b;
    logic [1:0]       com_a;
    logic [1:0]       com_b;
    logic [2:0]       wgm;
    logic [2:0]       cs;
    logic [2:0]       msk;
    logic [2:0]       flg;
    logic             oc_a;
    logic             oc_b;
    logic             down;
    logic             blk;
    logic [PSC_W-1:0] psc;
    logic             ext_q;
    logic             ack;
    logic [7:0]       rdat;
  } tcoc_state_t;

  tcoc_state_t st_r;
  tcoc_state_t st_nxt;

  logic       req;
  logic       wr;
  logic [7:0] wd;
  logic       tick;
  logic       pwm;
  logic       phase;
  logic       fast;
  logic [7:0] top;
  logic       hit_a;
  logic       hit_b;
  logic       frc_a;
  logic       frc_b;
  logic       wrap;
  logic       upd;
  logic [2:0] fset;
  logic [2:0] fclr;
  logic       wr_cnt;

  // Picks the timer tick from the prescaler taps or the pin edge.
  function automatic logic tick_of(logic [2:0] cs, logic [PSC_W-1:0] p,
                                   logic q, logic pin);
    logic t;
    t = 1'b0;
    case (cs)
      CS_DIV1:     t = 1'b1;
      CS_DIV8:     t = &p[DIV8_BITS-1:0];
      CS_DIV64:    t = &p[DIV64_BITS-1:0];
      CS_DIV256:   t = &p[DIV256_BITS-1:0];
      CS_DIV1024:  t = &p[DIV1024_BITS-1:0];
      CS_EXT_FALL: t = q & ~pin;
      CS_EXT_RISE: t = ~q & pin;
      default:     t = 1'b0;
    endcase
    return t;
  endfunction

  // Next state of one waveform output for a match, force or wrap event.
  function automatic logic wave_step(logic oc, logic [1:0] com,
                                     logic [2:0] wgm, logic hit,
                                     logic frc, logic wr_p, logic dn,
                                     logic chan_a);
    logic v;
    v = oc;
    if (wgm == WGM_PC_MAX || wgm == WGM_PC_OCA) begin
      // Phase correct: clear or set on match, flipped when counting down.
      if (hit && com[1]) begin
        v = com[0] ^ dn;
      end
    end else if (wgm == WGM_FAST_MAX || wgm == WGM_FAST_OCA) begin
      if (hit) begin
        if (com[1]) begin
          v = com[0];
        end else if (com == COM_TOGGLE && chan_a && wgm == WGM_FAST_OCA) begin
          v = ~oc;
        end
      end
      // At bottom the output returns to its idle level.
      if (wr_p && com[1]) begin
        v = ~com[0];
      end
    end else if (hit || frc) begin
      case (com)
        COM_TOGGLE: v = ~oc;
        COM_CLEAR:  v = 1'b0;
        COM_SET:    v = 1'b1;
        default:    v = oc;
      endcase
    end
    return v;
  endfunction

  // Mode decode and the selected timer tick.
  assign phase = (st_r.wgm == WGM_PC_MAX) || (st_r.wgm == WGM_PC_OCA);
  assign fast  = (st_r.wgm == WGM_FAST_MAX) || (st_r.wgm == WGM_FAST_OCA);
  assign pwm   = phase | fast;
  assign top   = (st_r.wgm == WGM_FAST_OCA || st_r.wgm == WGM_PC_OCA) ?
                 st_r.ocr_a : CNT_MAX;
  assign tick  = tick_of(st_r.cs, st_r.psc, st_r.ext_q,
                         ext_count_pin);

  // Bus request decode; writes land on the edge where ack is seen.
  assign req    = wb_cyc_i & wb_stb_i;
  assign wr     = req & st_r.ack & wb_we_i & wb_sel_i[0];
  assign wd     = wb_dat_i[7:0];
  assign wr_cnt = wr && wb_adr_i[7:2] == OFS_COUNT[7:2];

  // Match, force and extreme events for this cycle.
  always_comb begin
    hit_a = tick && st_r.cnt == st_r.ocr_a && !st_r.blk;
    hit_b = tick && st_r.cnt == st_r.ocr_b && !st_r.blk;
    frc_a = wr && wb_adr_i[7:2] == OFS_CTRL_B[7:2] &&
            wd[CTB_FOCA_POS] && !pwm;
    frc_b = wr && wb_adr_i[7:2] == OFS_CTRL_B[7:2] &&
            wd[CTB_FOCB_POS] && !pwm;
    wrap  = tick && fast && st_r.cnt == top;
    upd   = (fast && wrap) ||
            (phase && tick && !st_r.down && st_r.cnt == top);
  end

  // Next state: counter, compares, flags, outputs and the bus slave.
  always_comb begin
    st_nxt       = st_r;
    st_nxt.psc   = st_r.psc + 10'h001;
    st_nxt.ext_q = ext_count_pin;
    st_nxt.ack   = req & ~st_r.ack;
    fset         = 3'h0;
    fclr         = 3'h0;

    // Counting sequence on each tick.
    if (tick) begin
      st_nxt.blk = 1'b0;
      if (phase) begin
        if (!st_r.down) begin
          if (st_r.cnt == top) begin
            st_nxt.down = 1'b1;
            st_nxt.cnt  = (top == CNT_BOTTOM) ? CNT_BOTTOM :
                          st_r.cnt - 8'h01;
          end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
          end
        end else if (st_r.cnt == CNT_BOTTOM) begin
          st_nxt.down   = 1'b0;
          st_nxt.cnt    = st_r.cnt + 8'h01;
          fset[FLG_OVF] = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 8'h01;
        end
      end else if (fast) begin
        if (st_r.cnt == top) begin
          st_nxt.cnt    = CNT_BOTTOM;
          fset[FLG_OVF] = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + 8'h01;
        end
      end else if (st_r.wgm == WGM_CTC && st_r.cnt == st_r.ocr_a) begin
        st_nxt.cnt = CNT_BOTTOM;
      end else begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
      if (!pwm && st_r.cnt == CNT_MAX && st_nxt.cnt == CNT_BOTTOM) begin
        fset[FLG_OVF] = 1'b1;
      end
    end

    // Real matches raise compare flags; forced ones do not.
    fset[FLG_CMP_A] = hit_a;
    fset[FLG_CMP_B] = hit_b;

    // Buffered compare values move to the active registers.
    if (upd) begin
      st_nxt.ocr_a = st_r.buf_a;
      st_nxt.ocr_b = st_r.buf_b;
    end

    // Waveform outputs.
    st_nxt.oc_a = wave_step(st_r.oc_a, st_r.com_a, st_r.wgm, hit_a,
                            frc_a, wrap, st_r.down, 1'b1);
    st_nxt.oc_b = wave_step(st_r.oc_b, st_r.com_b, st_r.wgm, hit_b,
                            frc_b, wrap, st_r.down, 1'b0);

    // Register writes; a count write overrides the tick above.
    if (wr) begin
      case (wb_adr_i[7:2])
        OFS_COUNT[7:2]: begin
          st_nxt.cnt = wd;
          st_nxt.blk = 1'b1;
        end
        OFS_CMP_A[7:2]: begin
          st_nxt.buf_a = wd;
          if (!pwm) begin
            st_nxt.ocr_a = wd;
          end
        end
        OFS_CMP_B[7:2]: begin
          st_nxt.buf_b = wd;
          if (!pwm) begin
            st_nxt.ocr_b = wd;
          end
        end
        OFS_CTRL_A[7:2]: begin
          st_nxt.com_a      = wd[CTA_COMA_POS +: 2];
          st_nxt.com_b      = wd[CTA_COMB_POS +: 2];
          st_nxt.wgm[1:0]   = wd[CTA_WGM_POS +: 2];
        end
        OFS_CTRL_B[7:2]: begin
          st_nxt.cs     = wd[CTB_CS_POS +: 3];
          st_nxt.wgm[2] = wd[CTB_WGM2_POS];
        end
        OFS_MASK[7:2]: begin
          st_nxt.msk = wd[2:0];
        end
        OFS_FLAGS[7:2]: begin
          fclr = wd[2:0];
        end
        default: begin
        end
      endcase
    end

    // Serviced interrupts clear their flag; a new set wins.
    fclr = fclr | {irq_ack_cmp_b, irq_ack_cmp_a, irq_ack_ovf};
    st_nxt.flg = (st_r.flg & ~fclr) | fset;

    // Read data is captured in the cycle the request arrives.
    if (req && !st_r.ack) begin
      case (wb_adr_i[7:2])
        OFS_COUNT[7:2]:  st_nxt.rdat = st_r.cnt;
        OFS_CMP_A[7:2]:  st_nxt.rdat = st_r.buf_a;
        OFS_CMP_B[7:2]:  st_nxt.rdat = st_r.buf_b;
        OFS_CTRL_A[7:2]: st_nxt.rdat = {st_r.com_a, st_r.com_b, 2'h0,
                                        st_r.wgm[1:0]};
        OFS_CTRL_B[7:2]: st_nxt.rdat = {4'h0, st_r.wgm[2], st_r.cs};
        OFS_MASK[7:2]:   st_nxt.rdat = {5'h00, st_r.msk};
        OFS_FLAGS[7:2]:  st_nxt.rdat = {5'h00, st_r.flg};
        default:         st_nxt.rdat = RST_BYTE;
      endcase
    end
  end

  // State register; everything clears on reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs.
  assign wb_ack_o   = st_r.ack;
  assign wb_dat_o   = {24'h000000, st_r.rdat};
  assign irq_ovf    = st_r.flg[FLG_OVF] & st_r.msk[FLG_OVF];
  assign irq_cmp_a  = st_r.flg[FLG_CMP_A] & st_r.msk[FLG_CMP_A];
  assign irq_cmp_b  = st_r.flg[FLG_CMP_B] & st_r.msk[FLG_CMP_B];
  assign wave_out_a = st_r.oc_a;
  assign wave_out_b = st_r.oc_b;
  assign wave_oe_a  = st_r.com_a != COM_OFF;
  assign wave_oe_b  = st_r.com_b != COM_OFF;

  // A stopped timer keeps its count unless software writes it.
  a_stop_holds: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_r.cs == CS_STOP && !wr_cnt) |=> $stable(st_r.cnt))
    else $error("count moved while stopped");

  // A count write wins over the tick in the same cycle.
  a_write_wins: assert property (
    @(posedge clk) disable iff (!rstn)
    wr_cnt |=> st_r.cnt == $past(wb_dat_i[7:0]))
    else $error("count write lost");

  // Writing one clears a flag when nothing sets it.
  a_flag_clear: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr && wb_adr_i[7:2] == OFS_FLAGS[7:2] && wd[FLG_CMP_A] && !hit_a)
    |=> !st_r.flg[FLG_CMP_A])
    else $error("flag not cleared by one");

  // Writing zero never clears a flag.
  a_zero_keeps: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr && wb_adr_i[7:2] == OFS_FLAGS[7:2] && wd[2:0] == 3'h0 &&
     !irq_ack_ovf && !irq_ack_cmp_a && !irq_ack_cmp_b)
    |=> st_r.flg == ($past(st_r.flg) | $past(fset)))
    else $error("flag lost on zero write");

  // Flag A rises only from an unblocked tick with a match.
  a_match_blocked: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(st_r.flg[FLG_CMP_A]) |->
      $past(tick) && !$past(st_r.blk) &&
      $past(st_r.cnt) == $past(st_r.ocr_a))
    else $error("compare flag without valid match");

  // A forced match without a tick leaves flags and count alone.
  a_force_quiet: assert property (
    @(posedge clk) disable iff (!rstn)
    (frc_a && !tick) |=> $stable(st_r.cnt) && !$rose(st_r.flg[FLG_CMP_A]))
    else $error("force disturbed flag or count");

  // Clear-on-match mode returns to zero after matching A.
  a_ctc_clear: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_r.wgm == WGM_CTC && tick && st_r.cnt == st_r.ocr_a && !wr_cnt)
    |=> st_r.cnt == CNT_BOTTOM)
    else $error("counter not cleared on match");

  // Normal mode flags overflow as the count wraps to zero.
  a_normal_ovf: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_r.wgm == WGM_NORMAL && tick && st_r.cnt == CNT_MAX && !wr_cnt)
    |=> st_r.cnt == CNT_BOTTOM && st_r.flg[FLG_OVF])
    else $error("overflow missed at wrap");

  // Outside PWM the active compare follows a bus write at once.
  a_direct_cmp: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr && wb_adr_i[7:2] == OFS_CMP_B[7:2] && !pwm)
    |=> st_r.ocr_b == $past(wb_dat_i[7:0]))
    else $error("compare B not written directly");

endmodule

/* dv/tcoc_cpu_model.sv */
// Processor-side model: services interrupts and drives the count pin.
`timescale 1ns/10ps
module tcoc_cpu_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic svc_en,
  input  wire logic irq_ovf,
  input  wire logic irq_cmp_a,
  input  wire logic irq_cmp_b,
  output logic      ack_ovf,
  output logic      ack_cmp_a,
  output logic      ack_cmp_b,
  output logic      pin
);
  // A raised request gets one service pulse, never two in a row.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_ovf   <= 1'b0;
      ack_cmp_a <= 1'b0;
      ack_cmp_b <= 1'b0;
    end else begin
      ack_ovf   <= svc_en & irq_ovf & !ack_ovf;
      ack_cmp_a <= svc_en & irq_cmp_a & !ack_cmp_a;
      ack_cmp_b <= svc_en & irq_cmp_b & !ack_cmp_b;
    end
  end

  // The pin idles low; each pulse gives one rising and one falling edge.
  initial pin = 1'b0;
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      pin <= 1'b1;
      repeat (2) @(posedge clk);
      pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

/* dv/tb_tcoc_timer.sv */
// Self-checking bench for the timer with two compare channels.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_tcoc_timer;
  import tcoc_pkg::*;
  logic        clk, rstn, cyc, stb, we, svc_en, pin;
  logic        ack, i_ovf, i_a, i_b, k_ovf, k_a, k_b;
  logic        wa, wb_o, oa, ob;
  logic [7:0]  adr, e_now;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o;
  logic [15:0] rnd;
  logic [7:0]  exp_q[$];
  int          fail_count, compares;

  tcoc_timer tcoc_timer_i (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ext_count_pin(pin), .irq_ack_ovf(k_ovf), .irq_ack_cmp_a(k_a),
    .irq_ack_cmp_b(k_b), .irq_ovf(i_ovf), .irq_cmp_a(i_a),
    .irq_cmp_b(i_b), .wave_out_a(wa), .wave_out_b(wb_o),
    .wave_oe_a(oa), .wave_oe_b(ob));
  tcoc_cpu_model tcoc_cpu_model_i (.clk(clk), .rstn(rstn),
    .svc_en(svc_en), .irq_ovf(i_ovf), .irq_cmp_a(i_a), .irq_cmp_b(i_b),
    .ack_ovf(k_ovf), .ack_cmp_a(k_a), .ack_cmp_b(k_b), .pin(pin));

  // Clock at 100 MHz.
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Pseudo-random source for register values.
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // One classic cycle; holds the request until ack is sampled high.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // The write lands on the ack edge; one more edge lets it settle before
  // the caller looks at any output that the write changes.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    @(posedge clk);
  endtask

  // A read notes its expected byte before the cycle starts.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask

  // Exact numbers of timer ticks come from pulses on the count pin.
  task automatic ticks(input int n);
    tcoc_cpu_model_i.pulses(n);
    repeat (3) @(posedge clk);
  endtask

  // Read data is compared with the oldest note when ack appears.
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1) begin
      e_now = exp_q.pop_front();
      `CHK(dat_o, {24'h000000, e_now})
    end
  end

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog well beyond the length of the sequence.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict;
  end

  // Main sequence.
  initial begin
    rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
    sel = 4'hf; dat = 32'h0; svc_en = 1'b0; rnd = 16'h13a5;
    fail_count = 0; compares = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    `CHK({wa, wb_o, oa, ob, i_ovf, i_a, i_b, ack}, 8'h00)
    for (int a = 0; a < 8; a++) rd(8'(a * 4), 8'h00);
    // Byte lane zero off: the write is dropped.
    rnd = nxt(rnd);
    sel <= 4'h0;
    wr(OFS_CMP_B, rnd[7:0]);
    sel <= 4'hf;
    rd(OFS_CMP_B, 8'h00);
    // Count written and held while no clock is selected.
    wr(OFS_COUNT, rnd[15:8]);
    repeat (20) @(posedge clk);
    rd(OFS_COUNT, rnd[15:8]);
    // Normal mode: matches, overflow, flag clear, masks, service.
    wr(OFS_MASK, 8'h07);
    wr(OFS_CMP_A, 8'hfe);
    wr(OFS_CMP_B, 8'hff);
    wr(OFS_COUNT, 8'hfd);
    wr(OFS_CTRL_B, {5'h00, CS_EXT_RISE});
    ticks(2);
    rd(OFS_FLAGS, 8'h02);
    ticks(1);
    rd(OFS_FLAGS, 8'h07);
    rd(OFS_COUNT, 8'h00);
    `CHK({i_ovf, i_a, i_b}, 3'h7)
    wr(OFS_FLAGS, 8'h02);
    rd(OFS_FLAGS, 8'h05);
    wr(OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS, 8'h05);
    wr(OFS_MASK, 8'h01);
    `CHK({i_ovf, i_b}, 2'h2)
    svc_en <= 1'b1;
    repeat (4) @(posedge clk);
    svc_en <= 1'b0;
    rd(OFS_FLAGS, 8'h04);
    wr(OFS_FLAGS, 8'h07);
    // A count write equal to compare A hides the next match.
    wr(OFS_COUNT, 8'hfe);
    ticks(1);
    rd(OFS_FLAGS, 8'h00);
    rd(OFS_COUNT, 8'hff);
    ticks(1);
    wr(OFS_FLAGS, 8'h07);
    // Forced matches: toggle on A, set on B, no flag, no count change.
    wr(OFS_CTRL_A, {COM_TOGGLE, COM_SET, 4'h0});
    `CHK({oa, ob}, 2'h3)
    wr(OFS_CTRL_B, 8'hc0);
    repeat (2) @(posedge clk);
    `CHK({wa, wb_o}, 2'h3)
    rd(OFS_CTRL_B, 8'h00);
    rd(OFS_FLAGS, 8'h00);
    wr(OFS_CTRL_B, 8'hc0);
    repeat (2) @(posedge clk);
    `CHK({wa, wb_o}, 2'h1)
    rd(OFS_COUNT, 8'h00);
    // Clear on compare A, counted on falling pin edges.
    wr(OFS_CTRL_A, {COM_TOGGLE, COM_OFF, 2'h0, WGM_CTC[1:0]});
    wr(OFS_CMP_A, 8'h05);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CTRL_B, {5'h00, CS_EXT_FALL});
    ticks(8);
    rd(OFS_COUNT, 8'h02);
    rd(OFS_FLAGS, 8'h02);
    `CHK({wa, ob}, 2'h2)
    // Fast PWM: compare A buffered until the wrap at top.
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_A, {4'h0, 2'h0, WGM_FAST_MAX[1:0]});
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_CMP_A, 8'h3f);
    rd(OFS_CMP_A, 8'h3f);
    wr(OFS_COUNT, 8'h3e);
    wr(OFS_CTRL_B, {5'h00, CS_EXT_RISE});
    ticks(2);
    rd(OFS_FLAGS, 8'h00);
    wr(OFS_COUNT, 8'hfe);
    ticks(2);
    wr(OFS_COUNT, 8'h3e);
    ticks(2);
    rd(OFS_FLAGS, 8'h07);
    repeat (4) @(posedge clk);
    give_verdict;
  end
endmodule
